/* wwd_top.sv */
// Windowed watchdog: AHB-Lite register slave, 24-bit down counter,
// feed sequence and window checks, warning, interrupt and chip reset.
// Assumes oscillator levels synchronous to hclk and one AHB master.
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

module wwd_top #(
    parameter int WARN_W = 10
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Oscillators and power state
    input wire logic internal_rc_oscillator,
    input wire logic dedicated_watchdog_oscillator,
    input wire logic deep_sleep,
    // Outputs to the system
    output logic irq,
    output logic chip_reset,
    output logic wake
);

    if (WARN_W < 1 || WARN_W > 24) begin : g_bad_warn
        $error("wwd_top: WARN_W must lie in 1..24");
    end

    ////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic hready;
        logic pend;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] hrdata;
        logic [wwd_pkg::MODE_W-1:0] mode;
        logic [23:0] tc;
        logic [23:0] cnt;
        logic [WARN_W-1:0] warn;
        logic [23:0] window;
        logic running;
        logic feed_half;
        logic [wwd_pkg::ST_W-1:0] status;
        logic [wwd_pkg::ST_W-1:0] int_en;
        logic irq;
        logic [3:0] rst_cnt;
        logic chip_rst;
        logic wake;
    } wwd_state_t;

    localparam wwd_state_t RESET_STATE = '{
        hready: 1'b1,
        tc: wwd_pkg::TC_RESET,
        window: wwd_pkg::WINDOW_RESET,
        default: '0
    };

    wwd_state_t q;
    wwd_state_t d;

    // Helper signals
    logic tick;
    logic dec_strobe;
    logic addr_take;
    logic wr;
    logic feed_wr;
    logic key1;
    logic key2;
    logic bad_seq;
    logic feed_ok;
    logic early;
    logic fault;
    logic tmo;
    logic wev;
    logic advance;
    logic cnt_step;
    logic restart;
    logic [wwd_pkg::ST_W-1:0] clr;

    ////////////////////////////////////////////////////////////////////
    // Tick source and prescaler
    wwd_tick_src u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .internal_rc_oscillator(internal_rc_oscillator),
        .dedicated_watchdog_oscillator(dedicated_watchdog_oscillator),
        .sel(q.mode[wwd_pkg::MODE_TICK_SEL]),
        .tick(tick)
    );

    wwd_prescale #(
        .DIV(wwd_pkg::PRESCALE)
    ) u_pre (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .restart(restart),
        .strobe(dec_strobe)
    );

    ////////////////////////////////////////////////////////////////////
    // Event decode: feed sequence, window, count
    always_comb begin
        wr = q.pend & q.pwrite;
        feed_wr = wr & (q.paddr == wwd_pkg::ADDR_FEED);
        key1 = feed_wr & (hwdata[7:0] == wwd_pkg::FEED_KEY1);
        key2 = feed_wr & (hwdata[7:0] == wwd_pkg::FEED_KEY2);
        // Any access after the first key must be the second key
        feed_ok = q.feed_half & key2;
        bad_seq = q.pend & ((q.feed_half & ~key2) | (~q.feed_half & feed_wr & ~key1));
        early = feed_ok & q.running & (q.cnt > q.window);
        fault = q.mode[wwd_pkg::MODE_EN] & (bad_seq | early);
        // Sleep halts the count unless the user asked it to run
        advance = dec_strobe & q.running & (~deep_sleep | q.mode[wwd_pkg::MODE_SLEEP_RUN]);
        tmo = advance & (q.cnt == 24'h00_0000) & ~feed_ok;
        cnt_step = advance & (q.cnt != 24'h00_0000) & ~feed_ok & ~fault;
        wev = cnt_step & (q.cnt == 24'(q.warn));
        restart = feed_ok & ~fault;
        clr = (wr & (q.paddr == wwd_pkg::ADDR_INT_CLR)) ? hwdata[wwd_pkg::ST_W-1:0] : '0;
    end

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        addr_take = hsel & htrans[1] & hready & q.hready;

        // Bus: one wait cycle so reads see every earlier write
        if (addr_take) begin
            d.pend = 1'b1;
            d.hready = 1'b0;
            d.pwrite = hwrite;
            d.paddr = haddr[7:0];
        end
        if (q.pend) begin
            d.pend = 1'b0;
            d.hready = 1'b1;
            if (!q.pwrite) begin
                unique case (q.paddr)
                    wwd_pkg::ADDR_MODE: d.hrdata = 32'(q.mode);
                    wwd_pkg::ADDR_TC: d.hrdata = 32'(q.tc);
                    wwd_pkg::ADDR_TV: d.hrdata = 32'(q.cnt);
                    wwd_pkg::ADDR_WARN: d.hrdata = 32'(q.warn);
                    wwd_pkg::ADDR_WINDOW: d.hrdata = 32'(q.window);
                    wwd_pkg::ADDR_STATUS: d.hrdata = 32'(q.status);
                    wwd_pkg::ADDR_INT_EN: d.hrdata = 32'(q.int_en);
                    default: d.hrdata = 32'h0000_0000;
                endcase
            end
        end

        // Register writes
        if (wr) begin
            unique case (q.paddr)
                wwd_pkg::ADDR_MODE: begin
                    // Enable and reset mode are set-only
                    d.mode[wwd_pkg::MODE_EN] = q.mode[wwd_pkg::MODE_EN] | hwdata[wwd_pkg::MODE_EN];
                    d.mode[wwd_pkg::MODE_RST_EN] = q.mode[wwd_pkg::MODE_RST_EN] | hwdata[wwd_pkg::MODE_RST_EN];
                    // Source frozen while enabled, no switch mid-count
                    if (!q.mode[wwd_pkg::MODE_EN]) begin
                        d.mode[wwd_pkg::MODE_TICK_SEL] = hwdata[wwd_pkg::MODE_TICK_SEL];
                    end
                    if (hwdata[wwd_pkg::MODE_WD_FLAG]) begin
                        d.mode[wwd_pkg::MODE_WD_FLAG] = 1'b0;
                    end
                    d.mode[wwd_pkg::MODE_SLEEP_RUN] = hwdata[wwd_pkg::MODE_SLEEP_RUN];
                end
                wwd_pkg::ADDR_TC: begin
                    // Clamp keeps the shortest period at 255 steps
                    d.tc = (hwdata[23:0] < wwd_pkg::TC_MIN) ? wwd_pkg::TC_MIN : hwdata[23:0];
                end
                wwd_pkg::ADDR_WARN: d.warn = hwdata[WARN_W-1:0];
                wwd_pkg::ADDR_WINDOW: d.window = hwdata[23:0];
                wwd_pkg::ADDR_INT_EN: d.int_en = hwdata[wwd_pkg::ST_W-1:0];
                default: d.mode = d.mode;
            endcase
        end

        // Feed sequence tracking
        if (q.pend) begin
            d.feed_half = ~q.feed_half & key1;
        end
        if (restart) begin
            d.cnt = q.tc;
            d.running = q.mode[wwd_pkg::MODE_EN] | d.mode[wwd_pkg::MODE_EN];
        end

        // Down count, one step per prescaler strobe
        if (cnt_step) begin
            d.cnt = q.cnt - 24'h00_0001;
        end

        // Time-out or fault: reset or interrupt, and enable drops
        if (tmo | fault) begin
            d.mode[wwd_pkg::MODE_EN] = 1'b0;
            d.running = 1'b0;
            d.feed_half = 1'b0;
            if (q.mode[wwd_pkg::MODE_RST_EN]) begin
                d.rst_cnt = wwd_pkg::RST_HOLD;
                d.mode[wwd_pkg::MODE_WD_FLAG] = 1'b1;
                d.mode[wwd_pkg::MODE_RST_EN] = 1'b0;
            end
        end else if (q.rst_cnt != 4'h0) begin
            d.rst_cnt = q.rst_cnt - 4'h1;
        end

        // Sticky status: a new event beats a clear in the same cycle
        d.status = (q.status & ~clr);
        d.status[wwd_pkg::ST_TIMEOUT] = d.status[wwd_pkg::ST_TIMEOUT] | tmo;
        d.status[wwd_pkg::ST_WARN] = d.status[wwd_pkg::ST_WARN] | wev;
        d.status[wwd_pkg::ST_FAULT] = d.status[wwd_pkg::ST_FAULT] | fault;

        // Registered outputs
        d.irq = |(d.status & d.int_en);
        d.chip_rst = (d.rst_cnt != 4'h0);
        d.wake = deep_sleep & d.irq;
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops, hresp tied low
    assign hreadyout = q.hready;
    assign hresp = 1'b0;
    assign hrdata = q.hrdata;
    assign irq = q.irq;
    assign chip_reset = q.chip_rst;
    assign wake = q.wake;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    timeout_reset_a: assert property (tmo && q.mode[wwd_pkg::MODE_RST_EN] |=> chip_reset [*8] ##1 !chip_reset)
        else $error("time-out did not give an eight-cycle chip reset");

    early_feed_a: assert property (early && q.mode[wwd_pkg::MODE_EN] |=> q.status[wwd_pkg::ST_FAULT] && !q.running)
        else $error("early feed not flagged as fault");

    warn_flag_a: assert property (wev && q.int_en[wwd_pkg::ST_WARN] |=> q.status[wwd_pkg::ST_WARN] ##1 irq)
        else $error("warning did not raise status and interrupt");

    enable_lock_a: assert property (q.mode[wwd_pkg::MODE_EN] && !tmo && !fault |=> q.mode[wwd_pkg::MODE_EN])
        else $error("enable dropped without an event");

    bad_feed_a: assert property (bad_seq && q.mode[wwd_pkg::MODE_EN] && !q.mode[wwd_pkg::MODE_RST_EN]
        |=> q.status[wwd_pkg::ST_FAULT] && !chip_reset)
        else $error("bad feed in interrupt mode misbehaved");

    reset_flag_a: assert property ($rose(chip_reset) |-> q.mode[wwd_pkg::MODE_WD_FLAG])
        else $error("chip reset without watchdog flag");

    count_step_a: assert property (cnt_step |=> q.cnt == $past(q.cnt) - 24'h00_0001)
        else $error("counter did not step down by one");

    tc_floor_a: assert property (q.tc >= wwd_pkg::TC_MIN)
        else $error("time-out constant below floor");

    prescale_gap_a: assert property (dec_strobe |=> !dec_strobe [*7])
        else $error("decrement strobes closer than four ticks");

    feed_reload_a: assert property (restart |=> q.cnt == $past(q.tc))
        else $error("valid feed did not reload counter");

    bus_wait_a: assert property (addr_take |=> !hreadyout ##1 hreadyout)
        else $error("bus answer not after one wait cycle");

    // Read data may only move on the answer edge of a read
    read_hold_a: assert property (!q.pend |=> $stable(hrdata))
        else $error("read data changed outside an answer");

    // Events, enable lock and cause flag
    tmo_status_a: assert property (tmo |=> q.status[wwd_pkg::ST_TIMEOUT])
        else $error("time-out not recorded in status");

    reset_cause_a: assert property ($rose(chip_reset) |-> $past(tmo) || $past(fault))
        else $error("chip reset without a watchdog event");

    run_needs_en_a: assert property (q.running |-> q.mode[wwd_pkg::MODE_EN])
        else $error("counter running while disabled");

    fault_stop_a: assert property (fault |=> !q.running && !q.mode[wwd_pkg::MODE_EN])
        else $error("fault did not stop the watchdog");

    flag_sticky_a: assert property (q.mode[wwd_pkg::MODE_WD_FLAG] && !(wr && q.paddr == wwd_pkg::ADDR_MODE)
        |=> q.mode[wwd_pkg::MODE_WD_FLAG])
        else $error("reset cause flag lost without a write");

    // Tick source, power state and prescaler phase
    sel_frozen_a: assert property (q.mode[wwd_pkg::MODE_EN] |=> $stable(q.mode[wwd_pkg::MODE_TICK_SEL]))
        else $error("tick source changed while enabled");

    sleep_hold_a: assert property (deep_sleep && !q.mode[wwd_pkg::MODE_SLEEP_RUN] && !restart
        |=> $stable(q.cnt))
        else $error("counter moved in deep sleep");

    wake_sleep_a: assert property (wake |-> $past(deep_sleep))
        else $error("wake raised outside deep sleep");

    restart_phase_a: assert property (restart |=> !dec_strobe [*8])
        else $error("decrement came too soon after a reload");

endmodule

/* wwd_pkg.sv */
// Package of register map, field positions, reset values and counts
// for the windowed watchdog. Shared by the watchdog top and the testbench.
// Assumes a 32-bit AHB-Lite bus with word-aligned registers.
package wwd_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_TC = 8'h04;
    localparam logic [7:0] ADDR_FEED = 8'h08;
    localparam logic [7:0] ADDR_TV = 8'h0c;
    localparam logic [7:0] ADDR_WARN = 8'h10;
    localparam logic [7:0] ADDR_WINDOW = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_INT_CLR = 8'h1c;
    localparam logic [7:0] ADDR_INT_EN = 8'h20;

    ////////////////////////////////////////////////////////////////////
    // Mode register fields
    localparam int MODE_W = 5;
    localparam int MODE_EN = 0;
    localparam int MODE_RST_EN = 1;
    localparam int MODE_TICK_SEL = 2;
    localparam int MODE_WD_FLAG = 3;
    localparam int MODE_SLEEP_RUN = 4;

    // Status, clear and enable fields
    localparam int ST_W = 3;
    localparam int ST_TIMEOUT = 0;
    localparam int ST_WARN = 1;
    localparam int ST_FAULT = 2;

    ////////////////////////////////////////////////////////////////////
    // Feed keys and reset values
    localparam logic [7:0] FEED_KEY1 = 8'haa;
    localparam logic [7:0] FEED_KEY2 = 8'h55;
    localparam logic [23:0] TC_MIN = 24'h00_00ff;
    localparam logic [23:0] TC_RESET = 24'h00_00ff;
    localparam logic [23:0] WINDOW_RESET = 24'hff_ffff;

    // Prescaler ratio and chip reset hold length in hclk cycles
    localparam int PRESCALE = 4;
    localparam logic [3:0] RST_HOLD = 4'h8;

endpackage

/* wwd_tick_src.sv */
// Tick source select for the windowed watchdog.
// Both oscillator levels arrive synchronous to hclk and run slower
// than hclk / 2; the selected one yields a one-cycle tick on its rising edge.
`timescale 1ns/1ps

module wwd_tick_src (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Oscillator levels and selection
    input wire logic internal_rc_oscillator,
    input wire logic dedicated_watchdog_oscillator,
    input wire logic sel,
    // One-cycle tick
    output logic tick
);

    typedef struct packed {
        logic rc_prev;
        logic wd_osc_prev;
        logic tick;
    } wwd_tick_t;

    wwd_tick_t q;
    wwd_tick_t d;

    // Both edges tracked always, so a source switch gives no false tick
    always_comb begin
        d = q;
        d.rc_prev = internal_rc_oscillator;
        d.wd_osc_prev = dedicated_watchdog_oscillator;
        d.tick = sel ? (dedicated_watchdog_oscillator & ~q.wd_osc_prev)
                     : (internal_rc_oscillator & ~q.rc_prev);
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule

/* wwd_prescale.sv */
// Fixed prescaler of the windowed watchdog: one strobe per DIV ticks.
// Restart realigns the phase on every reload of the counter.
`timescale 1ns/1ps

module wwd_prescale #(
    parameter int DIV = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Tick in, realignment
    input wire logic tick,
    input wire logic restart,
    // Decrement strobe
    output logic strobe
);

    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    if (DIV < 2) begin : g_bad_div
        $error("wwd_prescale: DIV must be at least 2");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic strobe;
    } wwd_pre_t;

    wwd_pre_t q;
    wwd_pre_t d;

    // Divide the selected tick
    always_comb begin
        d = q;
        d.strobe = 1'b0;
        if (restart) begin
            d.cnt = '0;
        end else if (tick) begin
            if (q.cnt == LAST) begin
                d.cnt = '0;
                d.strobe = 1'b1;
            end else begin
                d.cnt = q.cnt + CW'(1);
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign strobe = q.strobe;

endmodule

/* tb.sv */
// Self-checking testbench for the windowed watchdog top.
// Assumes the package and design files are compiled ahead of it.
`timescale 1ns/1ps

module tb;

    ////////////////////////////////////////////////////////
    // Short register names and bench state
    localparam logic [7:0] MD = wwd_pkg::ADDR_MODE;
    localparam logic [7:0] TC = wwd_pkg::ADDR_TC;
    localparam logic [7:0] FD = wwd_pkg::ADDR_FEED;
    localparam logic [7:0] TV = wwd_pkg::ADDR_TV;
    localparam logic [7:0] WN = wwd_pkg::ADDR_WARN;
    localparam logic [7:0] WI = wwd_pkg::ADDR_WINDOW;
    localparam logic [7:0] ST = wwd_pkg::ADDR_STATUS;
    localparam logic [7:0] CL = wwd_pkg::ADDR_INT_CLR;
    localparam logic [7:0] IE = wwd_pkg::ADDR_INT_EN;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic internal_rc_oscillator = 1'b0;
    logic dedicated_watchdog_oscillator = 1'b0;
    logic deep_sleep = 1'b0;
    logic hreadyout, hresp, irq, chip_reset, wake;
    logic [31:0] hrdata, rdv, t1, v, e;
    logic [31:0] seed = 32'h146d_4d0c;
    logic [2:0] ph = 3'h0;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int rst_cyc = 0;

    // Single slave, so its ready is the bus ready
    wwd_top u_wwd_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .internal_rc_oscillator(internal_rc_oscillator),
        .dedicated_watchdog_oscillator(dedicated_watchdog_oscillator),
        .deep_sleep(deep_sleep), .irq(irq), .chip_reset(chip_reset),
        .wake(wake)
    );

    always #2 hclk = ~hclk;

    // Oscillators: RC rises every 4 cycles, watchdog osc every 8
    always @(posedge hclk) begin
        ph <= ph + 3'h1;
        internal_rc_oscillator <= ph[1];
        dedicated_watchdog_oscillator <= ph[2];
        cycles++;
        if (chip_reset === 1'b1) rst_cyc++;
        if (cycles == 60000) begin
            num_errors++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task test_done();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            num_errors++;
            $display("MISMATCH %s exp %h seen %h", n, x, s);
        end
    endtask

    // One AHB single transfer; held until ready is sampled high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rc(input string n, input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(n, rdv, x);
    endtask

    // Range check for counts that depend on tick phase
    task rng(input string n, input logic [31:0] lo, input logic [31:0] hi);
        xfer(1'b0, TV, 32'h0);
        chk(n, {31'h0, (rdv >= lo && rdv <= hi)}, 32'h1);
    endtask

    task feed();
        wr(FD, 32'haa);
        wr(FD, 32'h55);
    endtask

    ////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rc("mode_rst", MD, 32'h0);
        rc("tc_rst", TC, 32'hff);
        rc("tv_rst", TV, 32'h0);
        rc("win_rst", WI, 32'h00ff_ffff);
        rc("st_rst", ST, 32'h0);
        rc("ien_rst", IE, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rc("hole", 8'h40, 32'h0);
        // Random period and warning values; period floors at 255
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 32'h10 : seed;
            e = (v[23:0] < 24'h00_00ff) ? 32'hff : {8'h00, v[23:0]};
            wr(TC, v);
            rc("tc", TC, e);
            wr(WN, v);
            rc("warn", WN, {22'h0, v[9:0]});
        end
        // Countdown on the RC tick: one step per 16 hclk
        wr(WN, 32'h40);
        wr(TC, 32'h100);
        wr(MD, 32'h1);
        feed();
        rc("tv_load", TV, 32'h100);
        repeat (160) @(posedge hclk);
        rng("tv_rc", 32'hf4, 32'hf8);
        wr(MD, 32'h0);
        rc("en_lock", MD, 32'h1);
        // Warning, then time-out, in interrupt mode
        wr(IE, 32'h7);
        feed();
        while (irq !== 1'b1) @(posedge hclk);
        rc("warn_st", ST, 32'h2);
        rng("warn_tv", 32'h3f, 32'h40);
        wr(CL, 32'h2);
        rc("warn_clr", ST, 32'h0);
        chk("irq_off", {31'h0, irq}, 32'h0);
        rst_cyc = 0;
        while (irq !== 1'b1) @(posedge hclk);
        rc("to_st", ST, 32'h1);
        rc("to_en", MD, 32'h0);
        chk("to_nores", rst_cyc, 32'h0);
        // Early reload before the window opens is a fault
        wr(CL, 32'h7);
        feed();
        wr(WI, 32'h80);
        wr(MD, 32'h1);
        feed();
        // First feed starts the count; the next one comes too early
        feed();
        rc("win_early", ST, 32'h4);
        // Late reload inside the window is accepted
        wr(CL, 32'h7);
        wr(WI, 32'h00ff_ffff);
        wr(MD, 32'h1);
        feed();
        wr(WI, 32'h80);
        repeat (2400) @(posedge hclk);
        feed();
        rc("win_ok", ST, 32'h0);
        rc("win_tv", TV, 32'h100);
        // Bad key while running gives an interrupt, not a reset
        wr(WI, 32'h00ff_ffff);
        wr(FD, 32'h12);
        rc("bad_key", ST, 32'h4);
        chk("bad_irq", {31'h0, irq}, 32'h1);
        // Watchdog oscillator tick: one step per 32 hclk
        wr(CL, 32'h7);
        wr(MD, 32'h4);
        rc("sel", MD, 32'h4);
        wr(MD, 32'h5);
        feed();
        repeat (320) @(posedge hclk);
        rng("tv_wdo", 32'hf4, 32'hf8);
        // Deep sleep freezes the count unless sleep running is set
        deep_sleep <= 1'b1;
        repeat (4) @(posedge hclk);
        xfer(1'b0, TV, 32'h0);
        t1 = rdv;
        repeat (100) @(posedge hclk);
        rc("sleep_hold", TV, t1);
        // With sleep running set the count goes on
        wr(MD, 32'h15);
        repeat (100) @(posedge hclk);
        xfer(1'b0, TV, 32'h0);
        chk("sleep_run", {31'h0, rdv < t1}, 32'h1);
        // Key then a foreign access: chip reset, flag, wake
        wr(MD, 32'h7);
        rst_cyc = 0;
        wr(FD, 32'haa);
        rc("pre", MD, 32'h7);
        repeat (12) @(posedge hclk);
        chk("rst_len", rst_cyc, 32'h8);
        rc("flag", MD, 32'hc);
        chk("wake", {31'h0, wake}, 32'h1);
        wr(MD, 32'hc);
        rc("flag_clr", MD, 32'h4);
        deep_sleep <= 1'b0;
        // Missed reload in reset mode resets the chip
        wr(CL, 32'h7);
        wr(MD, 32'h0);
        wr(MD, 32'h3);
        feed();
        rst_cyc = 0;
        while (chip_reset !== 1'b1) @(posedge hclk);
        repeat (12) @(posedge hclk);
        chk("to_len", rst_cyc, 32'h8);
        rc("to_flag", MD, 32'h8);
        rc("to_st2", ST, 32'h3);
        test_done();
    end

endmodule
